// ---- hw/rcia_irq_aggregator.sv ----
// Radio core interrupt aggregator: shared radio line and diagnostic line.

module rcia_irq_aggregator #(
  parameter int BASE_CYCLES = rcia_pkg::BASE_CYCLES  // Clock cycles per base unit.
) (
  // Clock and reset.
  input  wire logic                              ref_clk,
  input  wire logic                              rst,
  // Mode.
  input  wire logic                              active_mode,
  // Radio core event pulses.
  input  wire logic                              sleep_end_evt,
  input  wire logic                              radio_error_evt,
  input  wire logic                              packet_rx_evt,
  input  wire logic                              event_end_evt,
  input  wire logic                              cipher_done_evt,
  input  wire logic                              sw_trigger_req,
  // Target timer control.
  input  wire logic [rcia_pkg::TIMER_W-1:0]      fine_target,
  input  wire logic                              fine_arm,
  input  wire logic [rcia_pkg::TIMER_W-1:0]      gross_target,
  input  wire logic                              gross_arm,
  // Pending source clear pulses.
  input  wire logic [rcia_pkg::NUM_SRC-1:0]      pending_clear,
  // Diagnostic events and selection.
  input  wire logic [rcia_pkg::DIAG_SEL_W-1:0]   diag_event_select,
  input  wire logic [rcia_pkg::DIAG_W-1:0]       diag_events,
  // Interrupt lines and status.
  output logic                                   radio_shared_irq,
  output logic                                   radio_diag_irq,
  output logic [rcia_pkg::NUM_SRC-1:0]           pending_status
);

  // ************************************************************
  // Time base
  // ************************************************************
  rcia_time_if tif ();  // Link to the divider and target timers.
  // Targets and arm pulses pass straight through; the timers keep no copy here.

  assign tif.fine_target  = fine_target;
  assign tif.gross_target = gross_target;
  assign tif.fine_arm     = fine_arm;
  assign tif.gross_arm    = gross_arm;

  rcia_timebase #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_timebase (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tb      (tif.timer)
  );

  // ************************************************************
  // Source set terms
  // ************************************************************
  logic [rcia_pkg::NUM_SRC-1:0] set_vec;      // Sources firing this cycle.
  logic [rcia_pkg::NUM_SRC-1:0] pending_r;    // Sticky pending sources.
  logic [rcia_pkg::NUM_SRC-1:0] pending_nxt;  // Next pending value.
  logic                         shared_r;     // Registered shared line.
  logic                         diag_r;       // Registered diagnostic line.

  // Every event is a one-cycle pulse; the tick only counts in active mode,
  // since the base tick would otherwise wake the processor needlessly.
  // Apart from the tick's mode gating, sources are not masked here; masking is left to the processor side.
  assign set_vec[rcia_pkg::SRC_FINE]    = tif.fine_expire;
  assign set_vec[rcia_pkg::SRC_GROSS]   = tif.gross_expire;
  assign set_vec[rcia_pkg::SRC_TICK]    = tif.tick & active_mode;
  assign set_vec[rcia_pkg::SRC_SLEEP]   = sleep_end_evt;
  assign set_vec[rcia_pkg::SRC_ERROR]   = radio_error_evt;
  assign set_vec[rcia_pkg::SRC_RX]      = packet_rx_evt;
  assign set_vec[rcia_pkg::SRC_EVT_END] = event_end_evt;
  assign set_vec[rcia_pkg::SRC_CIPHER]  = cipher_done_evt;
  assign set_vec[rcia_pkg::SRC_SW]      = sw_trigger_req;

  // ************************************************************
  // Pending flags
  // ************************************************************
  // A set in the same cycle as its clear wins, so no event is lost.
  // Clearing is per bit, so software may retire sources one at a time.
  genvar gi;
  generate
    for (gi = 0; gi < rcia_pkg::NUM_SRC; gi++) begin : g_pend
      assign pending_nxt[gi] = set_vec[gi] | (pending_r[gi] & ~pending_clear[gi]);
    end
  endgenerate

  // Shared line is taken from the next pending value so that it rises
  // together with the status and never lags it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pending_r <= rcia_pkg::PEND_RESET;
      shared_r  <= 1'b0;
    end else begin
      pending_r <= pending_nxt;
      shared_r  <= |pending_nxt;
    end
  end

  // ************************************************************
  // Diagnostic line
  // ************************************************************
  // The diagnostic line is a plain registered view of the chosen event;
  // it is not sticky because it serves debugging only.
  // A change of selection shows on the line one cycle later, like an event.
  wire diag_sel_bit = diag_events[diag_event_select];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      diag_r <= 1'b0;
    end else begin
      diag_r <= diag_sel_bit;
    end
  end

  // Every output is a plain view of a flop, so the pins never glitch.
  assign radio_shared_irq = shared_r;
  assign radio_diag_irq   = diag_r;
  assign pending_status   = pending_r;

  // ************************************************************
  // Checks
  // ************************************************************
  // The checks watch the flops and the set terms; a_shared_merge, a_diag_follow, a_tick_line and a_diag_quiet watch the pins.
  // A held event pulse simply sets again each cycle, which every check except a_fine_single and a_gross_single accepts.
  // Races of a set against a clear are checked last, apart from a_rx_pends, since they are easy to break.
  a_shared_merge: assert property (@(posedge ref_clk) disable iff (rst)
    (set_vec != '0) |=> radio_shared_irq && (pending_status != '0))
    else $error("Shared line differs from the pending summary.");

  a_fine_pends: assert property (@(posedge ref_clk) disable iff (rst)
    tif.fine_expire |=> pending_r[rcia_pkg::SRC_FINE] && shared_r)
    else $error("Fine expiry did not raise its source.");

  a_gross_pends: assert property (@(posedge ref_clk) disable iff (rst)
    tif.gross_expire |=> pending_r[rcia_pkg::SRC_GROSS] && shared_r)
    else $error("Gross expiry did not raise its source.");

  a_tick_active: assert property (@(posedge ref_clk) disable iff (rst)
    (tif.tick && active_mode) |=> pending_r[rcia_pkg::SRC_TICK])
    else $error("Base tick lost in active mode.");

  a_tick_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !pending_r[rcia_pkg::SRC_TICK] && !active_mode |=> !pending_r[rcia_pkg::SRC_TICK])
    else $error("Base tick raised outside active mode.");

  a_sleep_pends: assert property (@(posedge ref_clk) disable iff (rst)
    sleep_end_evt |=> pending_r[rcia_pkg::SRC_SLEEP])
    else $error("Sleep end did not raise its source.");

  a_error_pends: assert property (@(posedge ref_clk) disable iff (rst)
    radio_error_evt |=> pending_r[rcia_pkg::SRC_ERROR])
    else $error("Core error did not raise its source.");

  a_rx_pends: assert property (@(posedge ref_clk) disable iff (rst)
    packet_rx_evt && pending_clear[rcia_pkg::SRC_RX] |=> pending_r[rcia_pkg::SRC_RX])
    else $error("Receive event lost against a clear.");

  a_evt_end_pends: assert property (@(posedge ref_clk) disable iff (rst)
    event_end_evt |=> pending_r[rcia_pkg::SRC_EVT_END])
    else $error("Event end did not raise its source.");

  a_cipher_pends: assert property (@(posedge ref_clk) disable iff (rst)
    cipher_done_evt |=> pending_r[rcia_pkg::SRC_CIPHER])
    else $error("Cipher completion did not raise its source.");

  a_sw_pends: assert property (@(posedge ref_clk) disable iff (rst)
    sw_trigger_req |=> pending_r[rcia_pkg::SRC_SW] ##0 shared_r)
    else $error("Software request did not raise its source.");

  a_diag_follow: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 radio_diag_irq == $past(diag_sel_bit))
    else $error("Diagnostic line does not follow the selected event.");

  a_shared_hold: assert property (@(posedge ref_clk) disable iff (rst)
    shared_r && ((pending_r & ~pending_clear) != '0) |=> shared_r)
    else $error("Shared line fell while a source was still pending.");

  a_shared_drop: assert property (@(posedge ref_clk) disable iff (rst)
    ((pending_r & ~pending_clear) == '0) && (set_vec == '0) |=> !shared_r && pending_r == '0)
    else $error("Shared line stayed high after all sources cleared.");

  a_rx_set: assert property (@(posedge ref_clk) disable iff (rst)
    packet_rx_evt |=> pending_r[rcia_pkg::SRC_RX])
    else $error("Receive event did not raise its source.");

  a_tick_line: assert property (@(posedge ref_clk) disable iff (rst)
    (tif.tick && active_mode) |=> radio_shared_irq)
    else $error("Base tick in active mode did not raise the shared line.");

  a_fine_single: assert property (@(posedge ref_clk) disable iff (rst)
    tif.fine_expire |=> !tif.fine_expire)
    else $error("Fine expiry lasted more than one cycle.");

  a_gross_single: assert property (@(posedge ref_clk) disable iff (rst)
    tif.gross_expire |=> !tif.gross_expire)
    else $error("Gross expiry lasted more than one cycle.");

  a_diag_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    !diag_sel_bit |=> !radio_diag_irq)
    else $error("Diagnostic line high without its selected event.");

  // Set and clear races: the set must survive, a lone clear must land.
  a_clear_takes: assert property (@(posedge ref_clk) disable iff (rst)
    (pending_r & pending_clear & ~set_vec) != '0
      |=> (pending_r & $past(pending_clear) & ~$past(set_vec)) == '0)
    else $error("Clear of an idle source did not take.");

  a_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
    (set_vec & pending_clear) != '0
      |=> (pending_r & $past(set_vec) & $past(pending_clear))
          == ($past(set_vec) & $past(pending_clear)))
    else $error("Clear beat a set in the same cycle.");

endmodule

// ---- hw/rcia_pkg.sv ----
// Shared constants for the radio core interrupt aggregator.
package rcia_pkg;

  // ************************************************************
  // Source positions in the pending vector
  // ************************************************************
  localparam int NUM_SRC       = 9;   // Number of merged radio sources.
  localparam int SRC_FINE      = 0;   // Fine target timer expiry.
  localparam int SRC_GROSS     = 1;   // Gross target timer expiry.
  localparam int SRC_TICK      = 2;   // Base-time tick.
  localparam int SRC_SLEEP     = 3;   // End of sleep.
  localparam int SRC_ERROR     = 4;   // Core error.
  localparam int SRC_RX        = 5;   // Packet received.
  localparam int SRC_EVT_END   = 6;   // Advertising, scanning or connection event end.
  localparam int SRC_CIPHER    = 7;   // Cipher processing done.
  localparam int SRC_SW        = 8;   // Software trigger.
  localparam logic [8:0] PEND_RESET = 9'h000;  // All sources idle after reset.

  // ************************************************************
  // Processor interrupt line numbers
  // ************************************************************
  localparam int IRQ_LINE_SHARED = 1;  // Line carrying the merged radio request.
  localparam int IRQ_LINE_DIAG   = 8;  // Line carrying the diagnostic request.

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 25;      // Reference clock period.
  localparam int BASE_UNIT_NS  = 625000;  // Base time unit, 625 us.
  localparam int BASE_CYCLES   = BASE_UNIT_NS / CLK_PERIOD_NS;  // Clock cycles per unit.
  localparam int GROSS_RATIO   = 16;      // Base units per gross timer step.
  localparam int GROSS_SUB_W   = 4;       // Width of the base unit sub-counter.
  localparam logic [3:0] GROSS_SUB_LAST = 4'(GROSS_RATIO - 1);
  localparam int DIV_W         = 16;      // Width of the clock divider.
  localparam int TIMER_W       = 16;      // Width of both target timers.

  // ************************************************************
  // Diagnostic selection
  // ************************************************************
  localparam int DIAG_W     = 8;  // Number of internal diagnostic events.
  localparam int DIAG_SEL_W = 3;  // Width of the diagnostic event selection.

endpackage

// ---- hw/rcia_time_if.sv ----
// Interface between the aggregator core and its time base.
interface rcia_time_if;
  logic                         tick;          // One-cycle pulse per base unit.
  logic                         fine_expire;   // One-cycle fine timer expiry.
  logic                         gross_expire;  // One-cycle gross timer expiry.
  logic [rcia_pkg::TIMER_W-1:0] fine_target;   // Fine expiry count in base units.
  logic [rcia_pkg::TIMER_W-1:0] gross_target;  // Gross expiry count in gross steps.
  logic                         fine_arm;      // Arms the fine timer.
  logic                         gross_arm;     // Arms the gross timer.

  // Time base side.
  modport timer (
    output tick, fine_expire, gross_expire,
    input  fine_target, gross_target, fine_arm, gross_arm
  );

  // Aggregator side.
  modport core (
    input  tick, fine_expire, gross_expire,
    output fine_target, gross_target, fine_arm, gross_arm
  );
endinterface

// ---- hw/rcia_timebase.sv ----
// Base time divider with fine and gross target timers.
module rcia_timebase #(
  parameter int BASE_CYCLES = rcia_pkg::BASE_CYCLES
) (
  // Clock and reset.
  input wire logic   ref_clk,
  input wire logic   rst,
  // Link to the aggregator core.
  rcia_time_if.timer tb
);

  // ************************************************************
  // Divider
  // ************************************************************
  localparam logic [rcia_pkg::DIV_W-1:0] DIV_LAST = rcia_pkg::DIV_W'(BASE_CYCLES - 1);

  logic [rcia_pkg::DIV_W-1:0]       div_r;         // Cycle count inside a base unit.
  logic                             tick_r;        // Base unit pulse.
  logic [rcia_pkg::TIMER_W-1:0]     fine_cnt_r;    // Base units elapsed.
  logic [rcia_pkg::GROSS_SUB_W-1:0] gross_sub_r;   // Base units inside a gross step.
  logic [rcia_pkg::TIMER_W-1:0]     gross_cnt_r;   // Gross steps elapsed.
  logic                             fine_armed_r;  // Fine timer waiting for its target.
  logic                             gross_armed_r; // Gross timer waiting for its target.
  logic                             fine_exp_r;    // Registered fine expiry pulse.
  logic                             gross_exp_r;   // Registered gross expiry pulse.

  wire div_wrap   = (div_r == DIV_LAST);
  wire gross_step = tick_r && (gross_sub_r == rcia_pkg::GROSS_SUB_LAST);
  // A timer expires on its own step, base or gross, in which its count equals the target.
  wire fine_hit   = tick_r && fine_armed_r && (fine_cnt_r == tb.fine_target);
  wire gross_hit  = gross_step && gross_armed_r && (gross_cnt_r == tb.gross_target);

  // The divider runs free so that the timers keep time in every mode.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_wrap ? '0 : div_r + 1'b1;
      tick_r <= div_wrap;
    end
  end

  // ************************************************************
  // Target timers
  // ************************************************************
  // Fine timer steps once per base unit.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fine_cnt_r   <= '0;
      fine_armed_r <= 1'b0;
      fine_exp_r   <= 1'b0;
    end else begin
      fine_cnt_r   <= fine_cnt_r + rcia_pkg::TIMER_W'(tick_r);
      fine_armed_r <= tb.fine_arm | (fine_armed_r & ~fine_hit);
      fine_exp_r   <= fine_hit;
    end
  end

  // Gross timer steps once per sixteen base units.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gross_sub_r   <= '0;
      gross_cnt_r   <= '0;
      gross_armed_r <= 1'b0;
      gross_exp_r   <= 1'b0;
    end else begin
      gross_sub_r   <= gross_sub_r + rcia_pkg::GROSS_SUB_W'(tick_r);
      gross_cnt_r   <= gross_cnt_r + rcia_pkg::TIMER_W'(gross_step);
      gross_armed_r <= tb.gross_arm | (gross_armed_r & ~gross_hit);
      gross_exp_r   <= gross_hit;
    end
  end

  assign tb.tick         = tick_r;
  assign tb.fine_expire  = fine_exp_r;
  assign tb.gross_expire = gross_exp_r;

  // ************************************************************
  // Checks
  // ************************************************************
  a_tick_period: assert property (@(posedge ref_clk) disable iff (rst)
    tick_r |-> (div_r == '0) ##1 (div_r == 1))
    else $error("Base tick not aligned to divider wrap.");

  a_gross_cadence: assert property (@(posedge ref_clk) disable iff (rst)
    gross_exp_r |-> $past(gross_sub_r) == rcia_pkg::GROSS_SUB_LAST && $past(tick_r))
    else $error("Gross expiry off a gross step.");

endmodule

// ---- tb/rcia_nvic_model.sv ----
// Behavioural model of the processor interrupt controller inputs.
module rcia_nvic_model (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Interrupt lines from the aggregator.
  input  wire logic       shared_line,
  input  wire logic       diag_line,
  // Per-line pending flags and their acknowledge.
  input  wire logic [8:0] line_ack,
  output logic      [8:0] line_pend
);
  timeunit 1ns;
  timeprecision 100ps;
  // Level lines latch onto their numbered flag; a line still high beats its acknowledge.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      line_pend <= 9'h000;
    end else begin
      line_pend <= (line_pend & ~line_ack)
        | (9'(shared_line) << rcia_pkg::IRQ_LINE_SHARED)
        | (9'(diag_line) << rcia_pkg::IRQ_LINE_DIAG);
    end
  end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the radio core interrupt aggregator.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BASE = 8;  // Short base unit so a gross step takes only 128 cycles.
  logic        ref_clk, rst, active_mode, fine_arm, gross_arm;
  logic [5:0]  evt;  // Sleep, error, rx, event end, cipher, software.
  logic [15:0] fine_target, gross_target;
  logic [8:0]  pending_clear, pending_status, line_ack, line_pend;
  logic [2:0]  diag_event_select;
  logic [7:0]  diag_events;
  logic        radio_shared_irq, radio_diag_irq;
  int          n_mismatch, checked;

  // ************************************************************
  // Design and partner
  // ************************************************************
  rcia_irq_aggregator #(.BASE_CYCLES(BASE)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .active_mode(active_mode),
    .sleep_end_evt(evt[0]), .radio_error_evt(evt[1]), .packet_rx_evt(evt[2]),
    .event_end_evt(evt[3]), .cipher_done_evt(evt[4]), .sw_trigger_req(evt[5]),
    .fine_target(fine_target), .fine_arm(fine_arm),
    .gross_target(gross_target), .gross_arm(gross_arm),
    .pending_clear(pending_clear), .diag_event_select(diag_event_select),
    .diag_events(diag_events), .radio_shared_irq(radio_shared_irq),
    .radio_diag_irq(radio_diag_irq), .pending_status(pending_status));
  rcia_nvic_model nvic_u (
    .ref_clk(ref_clk), .rst(rst), .shared_line(radio_shared_irq),
    .diag_line(radio_diag_irq), .line_ack(line_ack), .line_pend(line_pend));

  // Clock toggles every half period of 25 ns.
  always #12.5 ref_clk = ~ref_clk;

  // Compares with case equality so an unknown never matches.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic give_verdict();
    $display("Counts: checked %0d, n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Outputs are quiet on the first edge after reset release.
  task automatic test_reset();
    @(posedge ref_clk);
    #1;
    check({radio_shared_irq, radio_diag_irq, pending_status}, 16'h0000, "after reset");
    $display("test reset done");
  endtask

  // Each event source sets its own bit one cycle later and raises line one.
  task automatic test_sources();
    for (int k = 0; k < 6; k++) begin
      @(posedge ref_clk);
      evt <= 6'(1 << k);
      line_ack <= 9'h1FF;
      @(posedge ref_clk);
      evt <= 6'h00;
      line_ack <= 9'h000;
      #1;
      check(16'(pending_status), 16'(9'h008 << k), "source bit");
      check(16'(radio_shared_irq), 16'h0001, "shared line");
      @(posedge ref_clk);
      pending_clear <= 9'(9'h008 << k);
      #1;
      check(16'(line_pend[1]), 16'h0001, "processor line one");
      @(posedge ref_clk);
      pending_clear <= 9'h000;
      #1;
      check({7'h00, radio_shared_irq, pending_status[7:0] | pending_status[8]}, 16'h0000,
            "after clear");
    end
    $display("test sources done");
  endtask

  // The line holds until the last bit goes; a set beats a clear in the same cycle.
  task automatic test_hold();
    @(posedge ref_clk);
    evt <= 6'h05;
    @(posedge ref_clk);
    evt <= 6'h04;
    pending_clear <= 9'h028;
    @(posedge ref_clk);
    evt <= 6'h00;
    pending_clear <= 9'h000;
    #1;
    check(16'(pending_status), 16'h0020, "set wins");
    check(16'(radio_shared_irq), 16'h0001, "line held");
    @(posedge ref_clk);
    pending_clear <= 9'h020;
    @(posedge ref_clk);
    pending_clear <= 9'h000;
    #1;
    check(16'(radio_shared_irq), 16'h0000, "line released");
    $display("test hold done");
  endtask

  // Every selection index routes its event to line eight, one cycle late.
  task automatic test_diag();
    for (int s = 0; s < 8; s++) begin
      @(posedge ref_clk);
      diag_event_select <= 3'(s);
      diag_events <= 8'(1 << s);
      @(posedge ref_clk);
      diag_events <= ~8'(1 << s);
      #1;
      check(16'(radio_diag_irq), 16'h0001, "diag high");
      @(posedge ref_clk);
      #1;
      check(16'(radio_diag_irq), 16'h0000, "diag low");
    end
    check(16'(line_pend[8]), 16'h0001, "processor line eight");
    $display("test diag done");
  endtask

  // Outside active mode no tick bit appears; unarmed timers stay silent.
  task automatic test_gate();
    @(posedge ref_clk);
    active_mode <= 1'b0;
    repeat (3 * BASE) @(posedge ref_clk);
    #1;
    check(16'(pending_status), 16'h0000, "gated tick");
    $display("test gate done");
  endtask

  // Counts tick bits after a fresh reset; fine fires on tick 3, gross on tick 16.
  task automatic test_timers();
    int  n, last, fine_at, gross_at;
    logic prev;
    n = 0;
    last = 0;
    fine_at = 0;
    gross_at = 0;
    prev = 1'b0;
    @(posedge ref_clk);
    rst <= 1'b1;
    active_mode <= 1'b1;
    fine_target <= 16'h0002;
    gross_target <= 16'h0000;
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    fine_arm <= 1'b1;
    gross_arm <= 1'b1;
    for (int cyc = 0; cyc < 20 * BASE && gross_at == 0; cyc++) begin
      @(posedge ref_clk);
      fine_arm <= 1'b0;
      gross_arm <= 1'b0;
      pending_clear <= {6'h00, prev, 2'b00};
      #1;
      if (pending_status[2] === 1'b1 && !prev) begin
        n++;
        if (n > 1) check(16'(cyc - last), 16'(BASE), "tick spacing");
        last = cyc;
      end
      prev = pending_status[2];
      if (pending_status[0] === 1'b1 && fine_at == 0) fine_at = n;
      if (pending_status[1] === 1'b1 && gross_at == 0) gross_at = n;
    end
    if (gross_at == 0) begin
      n_mismatch++;
      $display("MISMATCH at %0t ns: gross timer wait ran out", $time);
      give_verdict();
    end else begin
      check(16'(fine_at), 16'h0003, "fine expiry tick");
      check(16'(gross_at), 16'h0010, "gross expiry tick");
      check(16'(radio_shared_irq), 16'h0001, "line with timers pending");
      $display("test timers done");
    end
  endtask

  // Main sequence: 12 reset cycles, then each scenario in turn.
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    active_mode = 1'b0;
    evt = 6'h00;
    fine_target = 16'h0000;
    gross_target = 16'h0000;
    fine_arm = 1'b0;
    gross_arm = 1'b0;
    pending_clear = 9'h000;
    line_ack = 9'h000;
    diag_event_select = 3'h0;
    diag_events = 8'h00;
    n_mismatch = 0;
    checked = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    test_reset();
    test_sources();
    test_hold();
    test_diag();
    test_gate();
    test_timers();
    give_verdict();
  end
endmodule
